/* File: solc_consts.svh */
// Operation
// - B1h enters secured OTP mode region
// - C1h leaves OTP mode, main array
// - Reads and programs steer to OTP
// - Status and security writes refused in OTP
// - Locked OTP: only reads are valid
// - 2Bh returns security register repeatedly
// - Bit0 read-only factory lock indicator
// - 2Fh sets lock bit, no enable
// - Lock bit set: no more changes; here i_reset clears the lock bit
// - Security write needs byte-aligned deselect
// - No main array writes in OTP
// - Serial field 0-F, customer 10-1FF
`ifndef SOLC_CONSTS_SVH
`define SOLC_CONSTS_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SOLC_OP_ENTER 8'hb1
`define SOLC_OP_EXIT 8'hc1
`define SOLC_OP_RDSEC 8'h2b
`define SOLC_OP_WRSEC 8'h2f
`define SOLC_OP_WRSR1 8'h01
`define SOLC_OP_WRSR2 8'h31
`define SOLC_OP_PP 8'h02
`define SOLC_OP_SE 8'h20
`define SOLC_OP_BE32 8'h52
`define SOLC_OP_BE64 8'hd8
`define SOLC_OP_CE 8'hc7
// ----------------------------------------
// Fields and map
// ----------------------------------------
`define SOLC_BIT_FACT 0
`define SOLC_BIT_CUST 1
`define SOLC_SER_LAST 24'h00000f
`define SOLC_OTP_LAST 24'h0001ff
`define SOLC_BITS_BYTE 4'h8
`define SOLC_BYTE_LAST 4'h7
`define SOLC_ONE_BIT 4'h1
`define SOLC_ZERO_BYTE 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define SOLC_PUW_MS 10
`define SOLC_CLK_HZ 10000000
`define SOLC_PUW_CYC ((`SOLC_PUW_MS * `SOLC_CLK_HZ) / 1000)
`endif

/* File: solc_host_model.sv */
`timescale 1ns/100ps
module solc_host_model (
  // Pacing clock
  input wire logic i_sys_clk,
  // Serial link toward the device
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi,
  input wire logic i_miso,
  input wire logic i_miso_oe
);
  // ----------------------------------------
  // Idle levels: deselected, clock parked low
  // ----------------------------------------
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end

  // One link clock of 800 ns: data set while low, miso taken at the end of high
  task automatic tick(input logic b, output logic s, output logic oe);
    @(negedge i_sys_clk);
    o_mosi = b;
    repeat (3) @(negedge i_sys_clk);
    o_sclk = 1'b1;
    repeat (4) @(negedge i_sys_clk);
    s = i_miso;
    oe = i_miso_oe;
    o_sclk = 1'b0;
  endtask : tick

  // One framed command of n bits, MSB first; last 16 miso bits returned
  task automatic frame(input logic [31:0] bits, input int n, output logic [15:0] rd, output logic oe_all);
    logic s;
    logic oe;
    oe_all = 1'b1;
    rd = 16'h0000;
    @(negedge i_sys_clk);
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      tick(bits[i], s, oe);
      rd = {rd[14:0], s};
      if (i < 16) begin
        oe_all = oe_all & oe;
      end
    end
    repeat (4) @(negedge i_sys_clk);
    o_cs_n = 1'b1;
    // Released line no longer shows the last bit
    o_mosi = ~o_mosi;
    repeat (12) @(negedge i_sys_clk);
  endtask : frame
endmodule : solc_host_model

/* File: solc_otp_lock.sv */
`timescale 1ns/100ps
`include "solc_consts.svh"
module solc_otp_lock #(
  parameter int unsigned PUW_CYCLES = `SOLC_PUW_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Serial link pins
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  // Nonvolatile factory lock strap
  input wire logic i_factory_lock,
  // Access steering toward the array
  input wire logic [23:0] i_acc_addr,
  output solc_pkg::solc_steer_t o_steer,
  output logic o_otp_mode,
  output logic o_cust_lock,
  output logic o_opc_refused
);
  import solc_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stage pipes; third and second agree
  logic [2:0] cs_s_r, sclk_s_r, mosi_s_r;
  logic cs_n_r, sclk_r, mosi_r;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_s_r <= 3'h7;
      sclk_s_r <= 3'h0;
      mosi_s_r <= 3'h0;
    end else begin
      cs_s_r <= {cs_s_r[1:0], i_cs_n};
      sclk_s_r <= {sclk_s_r[1:0], i_sclk};
      mosi_s_r <= {mosi_s_r[1:0], i_mosi};
    end
  end

  // Filtered levels
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cs_n_r <= 1'b1;
      sclk_r <= 1'b0;
      mosi_r <= 1'b0;
    end else begin
      if (cs_s_r[1] == cs_s_r[2]) begin
        cs_n_r <= cs_s_r[2];
      end
      if (sclk_s_r[1] == sclk_s_r[2]) begin
        sclk_r <= sclk_s_r[2];
      end
      if (mosi_s_r[1] == mosi_s_r[2]) begin
        mosi_r <= mosi_s_r[2];
      end
    end
  end

  // Edge flags
  logic sclk_d_r, cs_d_r;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_r;
      cs_d_r <= cs_n_r;
    end
  end
  logic rise, fall, cs_end;
  assign rise = sclk_r & ~sclk_d_r & ~cs_n_r;
  assign fall = ~sclk_r & sclk_d_r & ~cs_n_r;
  assign cs_end = cs_n_r & ~cs_d_r;

  // ----------------------------------------
  // Power-up write wait
  // ----------------------------------------
  logic [23:0] puw_cnt_r;
  logic puw_done;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      puw_cnt_r <= 24'h000000;
    end else if (!puw_done) begin
      puw_cnt_r <= puw_cnt_r + 24'h000001;
    end
  end
  assign puw_done = (puw_cnt_r >= PUW_CYCLES[23:0]);

  // ----------------------------------------
  // Shift and command state
  // ----------------------------------------
  solc_state_t state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] wr_data_r;
  logic wr_full_r;
  logic [7:0] sec_byte;
  logic factory_r, cust_lock_r, otp_mode_r;

  // Security register image
  assign sec_byte = {6'h00, cust_lock_r, factory_r};

  // Is the command refused in the current condition
  function automatic logic refused(input logic [7:0] op, input logic otp, input logic lk);
    logic wr_sr, modify;
    wr_sr = (op == `SOLC_OP_WRSR1) || (op == `SOLC_OP_WRSR2) || (op == `SOLC_OP_WRSEC);
    modify = (op == `SOLC_OP_PP) || (op == `SOLC_OP_SE) || (op == `SOLC_OP_BE32) ||
             (op == `SOLC_OP_BE64) || (op == `SOLC_OP_CE);
    refused = (otp && wr_sr) || (otp && lk && modify);
  endfunction : refused

  logic [7:0] opc_nxt;
  assign opc_nxt = {shift_r[6:0], mosi_r};

  // Bit counter and shifter
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      shift_r <= `SOLC_ZERO_BYTE;
      bit_cnt_r <= 4'h0;
    end else if (cs_n_r) begin
      bit_cnt_r <= 4'h0;
    end else if (rise) begin
      shift_r <= opc_nxt;
      bit_cnt_r <= (bit_cnt_r == `SOLC_BITS_BYTE) ? `SOLC_ONE_BIT : bit_cnt_r + 4'h1;
    end
  end

  // Eighth bit of every byte; the wrap to one is the first bit of the next byte
  logic byte_done;
  assign byte_done = rise && (bit_cnt_r == `SOLC_BYTE_LAST);

  // Command decode
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= ST_OPC;
    end else if (cs_n_r) begin
      state_r <= ST_OPC;
    end else if (byte_done && state_r == ST_OPC) begin
      case (opc_nxt)
        `SOLC_OP_RDSEC: state_r <= ST_RDSEC;
        `SOLC_OP_WRSEC: state_r <= otp_mode_r ? ST_OTHER : ST_WRSEC;
        default: state_r <= ST_OTHER;
      endcase
    end
  end

  // Refusal flag
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_opc_refused <= 1'b0;
    end else if (byte_done && state_r == ST_OPC) begin
      o_opc_refused <= refused(opc_nxt, otp_mode_r, cust_lock_r | factory_r);
    end
  end

  // Data byte of the security write; last whole byte kept
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_data_r <= `SOLC_ZERO_BYTE;
      wr_full_r <= 1'b0;
    end else if (cs_n_r) begin
      wr_full_r <= 1'b0;
    end else if (byte_done && state_r == ST_WRSEC) begin
      wr_data_r <= opc_nxt;
      wr_full_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Mode and lock state
  // ----------------------------------------
  // Strap sampled on every clock after reset release
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      factory_r <= 1'b0;
    end else begin
      factory_r <= i_factory_lock;
    end
  end

  // OTP mode flag, cleared by reset
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      otp_mode_r <= 1'b0;
    end else if (byte_done && state_r == ST_OPC) begin
      if (opc_nxt == `SOLC_OP_ENTER) begin
        otp_mode_r <= 1'b1;
      end else if (opc_nxt == `SOLC_OP_EXIT) begin
        otp_mode_r <= 1'b0;
      end
    end
  end

  // Customer lock bit; cleared only by reset, set at deselect
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      cust_lock_r <= 1'b0;
    end else if (cs_end && state_r == ST_WRSEC && wr_full_r && bit_cnt_r == `SOLC_BITS_BYTE
                 && puw_done && !cust_lock_r) begin
      cust_lock_r <= wr_data_r[`SOLC_BIT_CUST];
    end
  end

  // ----------------------------------------
  // Output data
  // ----------------------------------------
  // Security byte shifted out MSB first on falling edges, repeating
  logic [2:0] out_idx_r;
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      out_idx_r <= 3'h7;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end else if (cs_n_r || state_r != ST_RDSEC) begin
      out_idx_r <= 3'h7;
      o_miso_oe <= 1'b0;
      o_miso <= 1'b0;
    end else if (fall) begin
      o_miso <= sec_byte[out_idx_r];
      o_miso_oe <= 1'b1;
      out_idx_r <= out_idx_r - 3'h1;
    end
  end

  // ----------------------------------------
  // Steering
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      o_steer <= '0;
      o_otp_mode <= 1'b0;
      o_cust_lock <= 1'b0;
    end else begin
      o_steer.otp_sel <= otp_mode_r && (i_acc_addr <= `SOLC_OTP_LAST);
      o_steer.wr_allow <= puw_done && !otp_mode_r ? 1'b1 :
                          (puw_done && !(cust_lock_r | factory_r) && (i_acc_addr <= `SOLC_OTP_LAST));
      o_steer.serial_area <= otp_mode_r && (i_acc_addr <= `SOLC_SER_LAST);
      o_otp_mode <= otp_mode_r;
      o_cust_lock <= cust_lock_r;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_lock_sticky: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $past(cust_lock_r) |-> cust_lock_r) else $error("lock bit cleared");
  a_otp_nowrite_main: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (o_otp_mode && o_steer.wr_allow) |-> o_steer.otp_sel) else $error("main write in OTP mode");
  a_enter_mode: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (byte_done && state_r == ST_OPC && opc_nxt == `SOLC_OP_ENTER) |=> otp_mode_r) else $error("no enter");
  a_exit_mode: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (byte_done && state_r == ST_OPC && opc_nxt == `SOLC_OP_EXIT) |=> !otp_mode_r) else $error("no exit");
  a_wrsec_refused: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (byte_done && state_r == ST_OPC && otp_mode_r) |=> state_r != ST_WRSEC) else $error("wrsec in OTP");
  a_miso_only_rd: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    o_miso_oe |-> $past(state_r == ST_RDSEC)) else $error("miso driven outside read");
  a_lock_needs_byte: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $rose(cust_lock_r) |-> $past(cs_end && bit_cnt_r == `SOLC_BITS_BYTE)) else $error("unaligned lock");
  a_locked_refuse: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (byte_done && state_r == ST_OPC && otp_mode_r && cust_lock_r && opc_nxt == `SOLC_OP_PP)
    |=> o_opc_refused) else $error("locked program accepted");
  c_enter: cover property (@(posedge i_sys_clk) $rose(otp_mode_r));
  c_lock: cover property (@(posedge i_sys_clk) $rose(cust_lock_r));
  c_read: cover property (@(posedge i_sys_clk) $rose(o_miso_oe));
endmodule : solc_otp_lock

/* File: solc_otp_lock_tb_top.sv */
`timescale 1ns/100ps
`include "solc_consts.svh"
module solc_otp_lock_tb_top;
  import solc_pkg::*;
  // Shortened power-up write delay
  localparam int unsigned PUW = 20;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic cs_n, sclk, mosi, miso, miso_oe, opc_refused, otp_mode, cust_lock;
  logic factory_lock = 1'b1;
  logic [23:0] acc_addr = 24'h000005;
  solc_steer_t steer;
  logic [15:0] rd;
  logic oe_all;
  int err_total = 0;
  int n_checks = 0;

  // ----------------------------------------
  // Clock, device and host
  // ----------------------------------------
  always #50 sys_clk = ~sys_clk;
  solc_otp_lock #(.PUW_CYCLES(PUW)) dut_u (.i_sys_clk(sys_clk), .i_reset(reset), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_mosi(mosi), .o_miso(miso), .o_miso_oe(miso_oe), .i_factory_lock(factory_lock), .i_acc_addr(acc_addr),
    .o_steer(steer), .o_otp_mode(otp_mode), .o_cust_lock(cust_lock), .o_opc_refused(opc_refused));
  solc_host_model host_u (.i_sys_clk(sys_clk), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi), .i_miso(miso),
    .i_miso_oe(miso_oe));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Opcode only, or opcode plus one data byte
  task automatic op(input logic [7:0] code);
    host_u.frame({24'h000000, code}, 8, rd, oe_all);
  endtask : op
  task automatic wr(input logic [7:0] data);
    host_u.frame({16'h0000, `SOLC_OP_WRSEC, data}, 16, rd, oe_all);
  endtask : wr

  // Read security byte twice in one frame
  task automatic rd_chk(input logic [7:0] exp);
    host_u.frame({8'h00, `SOLC_OP_RDSEC, 16'h0000}, 24, rd, oe_all);
    check(rd, {exp, exp}, "security read");
    check({15'h0000, oe_all}, 16'h0001, "miso enable");
  endtask : rd_chk

  task automatic results;
    if (err_total == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    results();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    check({15'h0000, otp_mode}, 16'h0000, "mode after reset");
    repeat (PUW) @(negedge sys_clk);
    rd_chk(8'h01);
    // Unlocked part from here, so OTP writes may be steered
    factory_lock = 1'b0;
    op(`SOLC_OP_ENTER);
    check({15'h0000, otp_mode}, 16'h0001, "enter");
    check({13'h0000, steer}, 16'h0007, "serial area steer");
    acc_addr = 24'h000010;
    repeat (2) @(negedge sys_clk);
    check({13'h0000, steer}, 16'h0006, "customer area steer");
    wr(8'h02);
    check({14'h0000, cust_lock, opc_refused}, 16'h0001, "lock write in mode");
    for (int k = 0; k < 2; k++) begin
      op(k == 0 ? `SOLC_OP_WRSR1 : `SOLC_OP_WRSR2);
      check({15'h0000, opc_refused}, 16'h0001, "status write in mode");
    end
    op(`SOLC_OP_EXIT);
    check({14'h0000, otp_mode, opc_refused}, 16'h0000, "exit");
    check({14'h0000, steer.otp_sel, steer.wr_allow}, 16'h0001, "main steer");
    host_u.frame({15'h0000, `SOLC_OP_WRSEC, 8'h02, 1'b1}, 17, rd, oe_all);
    check({15'h0000, cust_lock}, 16'h0000, "misaligned lock write");
    wr(8'h02);
    check({15'h0000, cust_lock}, 16'h0001, "lock write");
    rd_chk(8'h02);
    op(`SOLC_OP_ENTER);
    check({15'h0000, steer.wr_allow}, 16'h0000, "locked steer");
    op(`SOLC_OP_PP);
    check({15'h0000, opc_refused}, 16'h0001, "program when locked");
    op(`SOLC_OP_EXIT);
    wr(8'h00);
    check({15'h0000, cust_lock}, 16'h0001, "lock is permanent");
    // Mid-run reset while in OTP mode must drop the mode
    op(`SOLC_OP_ENTER);
    check({15'h0000, otp_mode}, 16'h0001, "enter again");
    reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    check({15'h0000, otp_mode}, 16'h0000, "mode after mid reset");
    results();
  end
endmodule : solc_otp_lock_tb_top

/* File: solc_pkg.sv */
package solc_pkg;
  // Command state of the serial front end
  typedef enum logic [1:0] {ST_OPC, ST_RDSEC, ST_WRSEC, ST_OTHER} solc_state_t;
  // Access steering result
  typedef struct packed {
    logic otp_sel;
    logic wr_allow;
    logic serial_area;
  } solc_steer_t;
endpackage : solc_pkg
